// *** rtl/motion_status.sv ***
// read-only temperature and event status registers of the motion sensor
// assumes the serial interface presents one-cycle rd/wr strobes on reg_req
// and that engines, enables and latch code come from surrounding logic

`timescale 1ns/1ps
`default_nettype none
module motion_status #(
  parameter int unsigned HOLD_CYCLES = motion_status_pkg::HOLD_CYCLES_DEF
) (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  var  motion_status_pkg::reg_req_t      reg_req,
  output var  motion_status_pkg::reg_rsp_t      reg_rsp,
  input  wire logic signed [7:0]                temp_sample,
  input  wire logic                             temp_strobe,
  input  var  motion_status_pkg::engine_flags_t engine_trig,
  input  var  motion_status_pkg::engine_flags_t engine_level,
  input  var  motion_status_pkg::engine_flags_t engine_enable,
  input  wire motion_status_pkg::latch_code_t   latch_code,
  input  wire logic                             clear_latched,
  input  var  motion_status_pkg::origin_t       tap_origin,
  input  var  motion_status_pkg::origin_t       slope_origin,
  output var  motion_status_pkg::engine_flags_t status_flags
);

  // ==========================================================
  // state
  typedef struct packed {
    logic signed [7:0]           temp;
    motion_status_pkg::reg_rsp_t rsp;
  } status_state_t;

  localparam status_state_t STATE_RESET = '{
    temp: motion_status_pkg::TEMP_RESET,
    rsp:  '0
  };

  status_state_t q;
  status_state_t d;

  motion_status_pkg::engine_flags_t flags;
  motion_status_pkg::origin_t       tap_q;
  motion_status_pkg::origin_t       slope_q;
  logic                             tap_capture;
  logic                             tap_enable;
  logic                             slope_capture;
  logic [7:0]                       word_motion;
  logic [7:0]                       word_queue;
  logic [7:0]                       word_origin;

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == motion_status_pkg::OFS_TEMP ||
           addr == motion_status_pkg::OFS_MOTION ||
           addr == motion_status_pkg::OFS_QUEUE ||
           addr == motion_status_pkg::OFS_ORIGIN;
  endfunction : is_mapped

  // ==========================================================
  // event flags
  // engine sets flag
  flag_latch #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_flag_latch (
    .clk           (clk),
    .rst_b         (rst_b),
    .trig          (engine_trig),
    .level         (engine_level),
    .enable        (engine_enable),
    .latch_code    (latch_code),
    .clear_latched (clear_latched),
    .flags         (flags)
  );

  assign status_flags = flags;

  // ==========================================================
  // event origin
  assign tap_enable    = engine_enable.single_tap | engine_enable.double_tap;
  assign tap_capture   = (engine_trig.single_tap & engine_enable.single_tap) |
                         (engine_trig.double_tap & engine_enable.double_tap);
  assign slope_capture = engine_trig.slope & engine_enable.slope;

  origin_capture u_tap_origin (
    .clk           (clk),
    .rst_b         (rst_b),
    .capture       (tap_capture),
    .enable        (tap_enable),
    .clear_latched (clear_latched),
    .origin_in     (tap_origin),
    .origin        (tap_q)
  );

  origin_capture u_slope_origin (
    .clk           (clk),
    .rst_b         (rst_b),
    .capture       (slope_capture),
    .enable        (engine_enable.slope),
    .clear_latched (clear_latched),
    .origin_in     (slope_origin),
    .origin        (slope_q)
  );

  // ==========================================================
  // register words
  // motion flag layout
  assign word_motion = {flags.flat, flags.orient, flags.single_tap,
                        flags.double_tap, flags.slow_no_motion, flags.slope,
                        flags.high_g, flags.low_g};
  assign word_queue  = {flags.data_ready, flags.queue_threshold_flag,
                        flags.queue_full, motion_status_pkg::RSVD_ZERO};
  assign word_origin = {tap_q, slope_q};

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.rsp = '0;
    if (temp_strobe) d.temp = temp_sample;
    if (reg_req.rd) begin
      d.rsp.valid = 1'b1;
      d.rsp.err   = !is_mapped(reg_req.addr);
      unique case (reg_req.addr)
        motion_status_pkg::OFS_TEMP:   d.rsp.data = q.temp;
        motion_status_pkg::OFS_MOTION: d.rsp.data = word_motion;
        motion_status_pkg::OFS_QUEUE:  d.rsp.data = word_queue;
        motion_status_pkg::OFS_ORIGIN: d.rsp.data = word_origin;
        default:                       d.rsp.data = motion_status_pkg::READ_ZERO;
      endcase
    end else if (reg_req.wr) begin
      d.rsp.valid = 1'b1;
      d.rsp.err   = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) q <= STATE_RESET;
    else q <= d;
  end

  assign reg_rsp = q.rsp;

  // ==========================================================
  // checks
  chk_temp_load: assert property (@(posedge clk) disable iff (!rst_b)
    temp_strobe |=> (q.temp == $past(temp_sample)))
    else $error("temperature sample not stored");

  chk_temp_read: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.rd && reg_req.addr == motion_status_pkg::OFS_TEMP)
    |=> (reg_rsp.valid && !reg_rsp.err && reg_rsp.data == $past(q.temp)))
    else $error("temperature readout differs from stored code");

  chk_trig_sets: assert property (@(posedge clk) disable iff (!rst_b)
    (engine_trig.slope && engine_enable.slope &&
     motion_status_pkg::latch_kind(latch_code) != motion_status_pkg::LK_NONE)
    |=> flags.slope)
    else $error("slope flag not set by its engine");

  chk_level_follow: assert property (@(posedge clk) disable iff (!rst_b)
    (motion_status_pkg::latch_kind(latch_code) == motion_status_pkg::LK_NONE &&
     engine_enable.high_g)
    |=> (flags.high_g == $past(engine_level.high_g)))
    else $error("unlatched flag does not follow its condition");

  chk_disabled_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !engine_enable.low_g |=> !flags.low_g)
    else $error("flag of a disabled engine is set");

  chk_motion_map: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.rd && reg_req.addr == motion_status_pkg::OFS_MOTION)
    |=> (reg_rsp.data == {$past(flags.flat), $past(flags.orient),
         $past(flags.single_tap), $past(flags.double_tap),
         $past(flags.slow_no_motion), $past(flags.slope),
         $past(flags.high_g), $past(flags.low_g)}))
    else $error("motion register layout wrong");

  chk_queue_map: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.rd && reg_req.addr == motion_status_pkg::OFS_QUEUE)
    |=> (reg_rsp.data == {$past(flags.data_ready),
         $past(flags.queue_threshold_flag), $past(flags.queue_full),
         motion_status_pkg::RSVD_ZERO}))
    else $error("queue register layout wrong or reserved bits set");

  // one quiet cycle between capture and read, as a host read normally lands
  chk_tap_origin: assert property (@(posedge clk) disable iff (!rst_b)
    (tap_capture ##1 (!tap_capture && !clear_latched && tap_enable)
     ##1 (reg_req.rd && reg_req.addr == motion_status_pkg::OFS_ORIGIN))
    |=> (reg_rsp.data[7:4] == $past(tap_origin, 3)))
    else $error("tap origin not reported in upper half");

  chk_slope_origin: assert property (@(posedge clk) disable iff (!rst_b)
    (slope_capture ##1 (!slope_capture && !clear_latched && engine_enable.slope)
     ##1 (reg_req.rd && reg_req.addr == motion_status_pkg::OFS_ORIGIN))
    |=> (reg_rsp.data[3:0] == $past(slope_origin, 3)))
    else $error("slope origin not reported in lower half");

  chk_write_refused: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.wr && !reg_req.rd && !temp_strobe)
    |=> (reg_rsp.valid && reg_rsp.err && $stable(q.temp)))
    else $error("write to read-only register not refused");

  chk_answer_once: assert property (@(posedge clk) disable iff (!rst_b)
    (!reg_req.rd && !reg_req.wr) |=> !reg_rsp.valid)
    else $error("answer without a request");

  cov_temp_read: cover property (@(posedge clk) disable iff (!rst_b)
    temp_strobe ##1 (reg_req.rd && reg_req.addr == motion_status_pkg::OFS_TEMP));

  cov_tap_read: cover property (@(posedge clk) disable iff (!rst_b)
    tap_capture ##[1:4] (reg_req.rd && reg_req.addr == motion_status_pkg::OFS_ORIGIN));

  cov_perm_clear: cover property (@(posedge clk) disable iff (!rst_b)
    flags.slope && clear_latched ##1 !flags.slope);

  cov_unmapped: cover property (@(posedge clk) disable iff (!rst_b)
    reg_req.rd ##1 reg_rsp.err);

endmodule : motion_status
`default_nettype wire

// *** rtl/motion_status_pkg.sv ***
// constants, carriers and latch decoding for the motion status block
// assumes a 100 MHz core clock and a register port from the serial interface
package motion_status_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TEMP   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MOTION = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_QUEUE  = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_ORIGIN = 8'h0B;
  localparam logic [DATA_W-1:0] TEMP_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;
  localparam int unsigned RSVD_W = 5;
  localparam logic [RSVD_W-1:0] RSVD_ZERO = 5'h00;

  // ==========================================================
  // latch configuration
  localparam int unsigned LATCH_W = 4;
  typedef logic [LATCH_W-1:0] latch_code_t;
  localparam latch_code_t LATCH_CODE_NONE     = 4'h0;
  localparam latch_code_t LATCH_CODE_PERM     = 4'h7;
  localparam latch_code_t LATCH_CODE_PERM_ALT = 4'hF;

  typedef enum logic [1:0] {
    LK_NONE = 2'b00,
    LK_TEMP = 2'b01,
    LK_PERM = 2'b10
  } latch_kind_t;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned HOLD_TIME_US    = 250;
  localparam int unsigned HOLD_CYCLES_DEF = (HOLD_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W = 24;
  typedef logic [HOLD_W-1:0] hold_cnt_t;

  // ==========================================================
  // carriers
  localparam int unsigned NUM_FLAGS = 11;
  typedef struct packed {
    logic flat;
    logic orient;
    logic single_tap;
    logic double_tap;
    logic slow_no_motion;
    logic slope;
    logic high_g;
    logic low_g;
    logic data_ready;
    logic queue_threshold_flag;
    logic queue_full;
  } engine_flags_t;

  typedef struct packed {
    logic sign;
    logic first_z;
    logic first_y;
    logic first_x;
  } origin_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic              valid;
    logic              err;
    logic [DATA_W-1:0] data;
  } reg_rsp_t;

  function automatic latch_kind_t latch_kind(input latch_code_t code);
    if (code == LATCH_CODE_NONE) return LK_NONE;
    if (code == LATCH_CODE_PERM || code == LATCH_CODE_PERM_ALT) return LK_PERM;
    return LK_TEMP;
  endfunction : latch_kind

endpackage : motion_status_pkg

// *** rtl/flag_latch.sv ***
// per-engine status flag latching: none, timed or permanent
// assumes trigger pulses and condition levels synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module flag_latch #(
  parameter int unsigned HOLD_CYCLES = motion_status_pkg::HOLD_CYCLES_DEF
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  var  motion_status_pkg::engine_flags_t trig,
  input  var  motion_status_pkg::engine_flags_t level,
  input  var  motion_status_pkg::engine_flags_t enable,
  input  wire motion_status_pkg::latch_code_t   latch_code,
  input  wire logic                          clear_latched,
  output var  motion_status_pkg::engine_flags_t flags
);
  localparam int unsigned NF = motion_status_pkg::NUM_FLAGS;
  localparam motion_status_pkg::hold_cnt_t HOLD_LOAD =
    motion_status_pkg::hold_cnt_t'(HOLD_CYCLES);
  localparam motion_status_pkg::hold_cnt_t HOLD_LAST =
    motion_status_pkg::hold_cnt_t'(1);

  typedef struct packed {
    logic [NF-1:0]                               flag;
    motion_status_pkg::hold_cnt_t [NF-1:0]       timer;
  } latch_state_t;

  latch_state_t q;
  latch_state_t d;
  logic [NF-1:0] trig_v;
  logic [NF-1:0] level_v;
  logic [NF-1:0] en_v;
  motion_status_pkg::latch_kind_t kind;

  assign trig_v  = trig;
  assign level_v = level;
  assign en_v    = enable;
  assign kind    = motion_status_pkg::latch_kind(latch_code);
  assign flags   = q.flag;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    for (int i = 0; i < NF; i++) begin
      if (!en_v[i]) begin
        d.flag[i]  = 1'b0;
        d.timer[i] = '0;
      end else begin
        unique case (kind)
          motion_status_pkg::LK_NONE: begin
            d.flag[i]  = level_v[i];
            d.timer[i] = '0;
          end
          motion_status_pkg::LK_PERM: begin
            // set wins over clear
            if (trig_v[i]) d.flag[i] = 1'b1;
            else if (clear_latched) d.flag[i] = 1'b0;
            d.timer[i] = '0;
          end
          motion_status_pkg::LK_TEMP: begin
            if (trig_v[i]) begin
              d.flag[i]  = 1'b1;
              d.timer[i] = HOLD_LOAD;
            end else if (clear_latched) begin
              d.flag[i]  = 1'b0;
              d.timer[i] = '0;
            end else if (q.timer[i] != '0) begin
              d.timer[i] = q.timer[i] - HOLD_LAST;
              if (q.timer[i] == HOLD_LAST) d.flag[i] = 1'b0;
            end
          end
          default: begin
            d.flag[i]  = 1'b0;
            d.timer[i] = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) q <= '0;
    else q <= d;
  end

  // ==========================================================
  // checks
  // the flag seen now was decided by kind, clear and enable of the previous cycle
  chk_perm_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(kind) == motion_status_pkg::LK_PERM && !$past(clear_latched))
    |-> ((q.flag & $past(q.flag & en_v)) == $past(q.flag & en_v)))
    else $error("permanent flag dropped without clear");

endmodule : flag_latch
`default_nettype wire

// *** rtl/origin_capture.sv ***
// captures sign and first axis of the event that fired last
// assumes origin bits are valid in the cycle of the capture pulse
`timescale 1ns/1ps
`default_nettype none
module origin_capture (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      capture,
  input  wire logic                      enable,
  input  wire logic                      clear_latched,
  input  var  motion_status_pkg::origin_t origin_in,
  output var  motion_status_pkg::origin_t origin
);
  motion_status_pkg::origin_t q;
  motion_status_pkg::origin_t d;

  assign origin = q;

  // ==========================================================
  // next state: a new event overwrites every bit, so idle axes clear
  always_comb begin
    d = q;
    if (!enable) d = '0;
    else if (capture) d = origin_in;
    else if (clear_latched) d = '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) q <= '0;
    else q <= d;
  end

  chk_origin_load: assert property (@(posedge clk) disable iff (!rst_b)
    (capture && enable) |=> (origin == $past(origin_in)))
    else $error("origin not captured from triggering event");

endmodule : origin_capture
`default_nettype wire

// *** test/host_reader.sv ***
// host side model: issues single register reads and writes
// assumes one-cycle strobes and an answer registered at the taking edge
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input  wire logic                        clk,
  output var  motion_status_pkg::reg_req_t reg_req,
  input  var  motion_status_pkg::reg_rsp_t reg_rsp
);
  initial reg_req = '0;

  // ==========================================================
  // one access, answer taken 1 ns after the taking edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] data, output logic err, output logic valid);
    @(posedge clk);
    #1;
    reg_req.rd   = ~wr;
    reg_req.wr   = wr;
    reg_req.addr = addr;
    reg_req.wdata = (addr == motion_status_pkg::OFS_QUEUE) ? {wdata[7:5], 3'h0, 2'h0} : wdata;
    @(posedge clk);
    #1;
    valid = reg_rsp.valid;
    err   = reg_rsp.err;
    data  = reg_rsp.data;
    // released strobes drop to zero; address and data show the inverse, never the old value
    reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~reg_req.wdata};
  endtask : access
endmodule : host_reader
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench of the motion status registers
// assumes host_reader as register partner and a short hold time
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned HOLD  = 5;
  localparam int          LIMIT = 6000;
  logic                             clk;
  logic                             rst_b;
  logic signed [7:0]                temp_sample;
  logic                             temp_strobe;
  motion_status_pkg::engine_flags_t trig;
  motion_status_pkg::engine_flags_t level;
  motion_status_pkg::engine_flags_t en;
  motion_status_pkg::latch_code_t   latch_code;
  logic                             clear_latched;
  motion_status_pkg::origin_t       tap_o;
  motion_status_pkg::origin_t       slope_o;
  motion_status_pkg::engine_flags_t flags;
  motion_status_pkg::reg_req_t      reg_req;
  motion_status_pkg::reg_rsp_t      reg_rsp;
  int                               bad_count;
  int                               checks_done;
  int                               cycles;
  logic [7:0]                       tcorner [4] = '{8'h80, 8'h7F, 8'h00, 8'hFB};

  motion_status #(.HOLD_CYCLES(HOLD)) i_motion_status (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .temp_sample(temp_sample), .temp_strobe(temp_strobe), .engine_trig(trig),
    .engine_level(level), .engine_enable(en), .latch_code(latch_code),
    .clear_latched(clear_latched), .tap_origin(tap_o), .slope_origin(slope_o),
    .status_flags(flags));
  host_reader i_host_reader (.clk(clk), .reg_req(reg_req), .reg_rsp(reg_rsp));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic cmp(input logic [10:0] got, input logic [10:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                      input logic err, input logic [7:0] exp);
    logic [7:0] d;
    logic       e;
    logic       v;
    i_host_reader.access(wr, addr, wdata, d, e, v);
    cmp({1'b0, v, e, d}, {1'b0, 1'b1, err, exp}, "register answer");
  endtask : xfer

  task automatic fire(input motion_status_pkg::engine_flags_t f);
    trig = f;
    tick(1);
    trig = '0;
  endtask : fire

  task automatic wipe_flags();
    clear_latched = 1'b1;
    tick(1);
    clear_latched = 1'b0;
    tick(1);
  endtask : wipe_flags

  function automatic logic [7:0] motion_byte(input motion_status_pkg::engine_flags_t f);
    return {f.flat, f.orient, f.single_tap, f.double_tap, f.slow_no_motion, f.slope,
            f.high_g, f.low_g};
  endfunction : motion_byte

  function automatic logic [7:0] queue_byte(input motion_status_pkg::engine_flags_t f);
    return {f.data_ready, f.queue_threshold_flag, f.queue_full, 5'h00};
  endfunction : queue_byte

  // 0 follows level, 1 timed, 2 permanent
  function automatic int latch_expect(input logic [3:0] c);
    if (c == 4'h0) return 0;
    if (c == 4'h7 || c == 4'hF) return 2;
    return 1;
  endfunction : latch_expect

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // main sequence
  initial begin
    int                               i;
    int                               k;
    logic [7:0]                       t;
    motion_status_pkg::engine_flags_t f;
    motion_status_pkg::origin_t       o1;
    motion_status_pkg::origin_t       o2;
    clk = 1'b0;
    rst_b = 1'b0;
    temp_sample = '0;
    temp_strobe = 1'b0;
    trig = '0;
    level = '0;
    en = '0;
    latch_code = 4'h7;
    clear_latched = 1'b0;
    tap_o = '0;
    slope_o = '0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(93));
    tick(12);
    rst_b = 1'b1;
    for (i = 8; i < 12; i++) xfer(1'b0, 8'(i), 8'h00, 1'b0, 8'h00);
    cmp(flags, '0, "flags after reset");
    for (i = 0; i < 12; i++) begin
      t = (i < 4) ? tcorner[i] : 8'($urandom);
      temp_sample = t;
      temp_strobe = 1'b1;
      tick(1);
      temp_strobe = 1'b0;
      temp_sample = ~t;
      xfer(1'b0, motion_status_pkg::OFS_TEMP, 8'h00, 1'b0, t);
    end
    // one flag at a time, permanent latch
    en = '1;
    for (i = 0; i < 11; i++) begin
      f = motion_status_pkg::engine_flags_t'(11'h001 << i);
      fire(f);
      cmp(flags, f, "single flag");
      xfer(1'b0, motion_status_pkg::OFS_MOTION, 8'h00, 1'b0, motion_byte(f));
      xfer(1'b0, motion_status_pkg::OFS_QUEUE, 8'h00, 1'b0, queue_byte(f));
      wipe_flags();
    end
    fire('1);
    en = motion_status_pkg::engine_flags_t'($urandom);
    tick(1);
    cmp(flags, en, "enable mask");
    en = '0;
    fire('1);
    cmp(flags, '0, "disabled trigger");
    en = '1;
    wipe_flags();
    // every latch code: level, timed, permanent
    for (i = 0; i < 16; i++) begin
      latch_code = 4'(i);
      k = latch_expect(latch_code);
      f = '0;
      f.slope = 1'b1;
      fire(f);
      cmp(flags, (k == 0) ? '0 : f, "latched at trigger");
      tick(HOLD - 1);
      cmp(flags, (k == 0) ? '0 : f, "latched at hold end");
      tick(1);
      cmp(flags, (k == 2) ? f : '0, "latched after hold");
      wipe_flags();
    end
    latch_code = 4'h0;
    level = motion_status_pkg::engine_flags_t'($urandom);
    tick(2);
    cmp(flags, level, "level following");
    xfer(1'b0, motion_status_pkg::OFS_MOTION, 8'h00, 1'b0, motion_byte(level));
    level = '0;
    // origin nibbles, tap and slope apart
    latch_code = 4'h7;
    wipe_flags();
    for (i = 0; i < 8; i++) begin
      o1 = 4'($urandom);
      o2 = 4'($urandom);
      tap_o = o1;
      slope_o = o2;
      f = '0;
      f.double_tap = i[0];
      f.single_tap = ~i[0];
      f.slope = 1'b1;
      fire(f);
      tap_o = ~o1;
      slope_o = ~o2;
      xfer(1'b0, motion_status_pkg::OFS_ORIGIN, 8'h00, 1'b0, {o1, o2});
      f = '0;
      f.slope = 1'b1;
      fire(f);
      xfer(1'b0, motion_status_pkg::OFS_ORIGIN, 8'h00, 1'b0, {o1, ~o2});
    end
    // writes refused, reads leave state alone, unmapped refused
    for (i = 8; i < 12; i++) xfer(1'b1, 8'(i), 8'($urandom), 1'b1, 8'h00);
    xfer(1'b0, motion_status_pkg::OFS_ORIGIN, 8'h00, 1'b0, {o1, ~o2});
    xfer(1'b0, motion_status_pkg::OFS_MOTION, 8'h00, 1'b0, 8'h34);
    xfer(1'b0, motion_status_pkg::OFS_MOTION, 8'h00, 1'b0, 8'h34);
    xfer(1'b0, 8'h0C, 8'h00, 1'b1, 8'h00);
    xfer(1'b0, 8'h07, 8'h00, 1'b1, 8'h00);
    // trigger beats a clear in the same cycle; untriggered origins clear
    clear_latched = 1'b1;
    fire(f);
    clear_latched = 1'b0;
    cmp(flags, f, "set wins over clear");
    xfer(1'b0, motion_status_pkg::OFS_ORIGIN, 8'h00, 1'b0, {4'h0, ~o2});
    wipe_flags();
    cmp(flags, '0, "flags after clear");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
